// ---- ipd_chk.sv ----
`timescale 1ns/100ps
`default_nettype none

module ipd_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // register port
  input wire logic [ipd_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // samples and flags
  input wire logic [ipd_pkg::SAMPLE_W-1:0] sample_i,
  input wire logic [ipd_pkg::SAMPLE_W-1:0] sample_q,
  input wire logic sample_valid,
  input wire logic irq_cleared,
  input wire logic power_cross_event,
  input wire logic power_protect_flag
);
  import ipd_pkg::*;
  // ----
  // checks
  // ----
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_ctrl_wr_rd;
    reg_wr && reg_addr == OFS_AVG_CTRL ##2 reg_rd && reg_addr == OFS_AVG_CTRL;
  endsequence
  chk_event_gap: assert property (power_cross_event |=> (!power_cross_event)[*8])
    else $error("event gap");
  chk_event_flag: assert property (power_cross_event |-> power_protect_flag)
    else $error("event without flag");
  chk_flag_cause: assert property ($rose(power_protect_flag) |-> power_cross_event)
    else $error("flag without event");
  chk_flag_hold: assert property (power_protect_flag && !irq_cleared |=> power_protect_flag)
    else $error("flag dropped");
  chk_flag_clear: assert property (irq_cleared |=> !power_protect_flag || power_cross_event)
    else $error("flag kept");
  chk_ctrl_rdbk: assert property (s_ctrl_wr_rd |=>
    reg_rdata[7:4] == {$past(reg_wdata[7], 3), 3'h0})
    else $error("ctrl readback");
  chk_thr_rsv: assert property (reg_rd && reg_addr == OFS_THR_HIGH |=> reg_rdata[7:5] == 3'h0)
    else $error("thr reserved");
  chk_pwr_rsv: assert property (reg_rd && reg_addr == OFS_PWR_HIGH |=> reg_rdata[7:5] == 3'h0)
    else $error("pwr reserved");
endmodule

`default_nettype wire

// ---- ipd_detector.sv ----
// Contract
// - averaging runs only while enable bit 7 of averaging control is one
// - average spans 2^(9+exponent) pairs, exponent 0 through 10
// - below threshold the readback shows the current average of I2+Q2
// - after crossing, readback holds the peak until the interrupt is cleared
// - only the seven top bits of I and Q enter the power sum
// - average compares against the 13-bit threshold, low byte and five high bits
// - crossing the threshold drives the protect flag high
`timescale 1ns/100ps
`default_nettype none

module ipd_detector (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // register port
  input wire logic [ipd_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // sample stream
  input wire logic [ipd_pkg::SAMPLE_W-1:0] sample_i,
  input wire logic [ipd_pkg::SAMPLE_W-1:0] sample_q,
  input wire logic sample_valid,
  // interrupt register hand-off
  input wire logic irq_cleared,
  output logic power_cross_event,
  // protection
  output logic power_protect_flag
);
  import ipd_pkg::*;

  typedef struct packed {
    logic power_calc_enable;
    logic [EXP_W-1:0] averaging_length_exponent;
    logic [PWR_W-1:0] power_limit_value;
    logic [ACC_W-1:0] acc;
    logic [CNT_W-1:0] cnt;
    logic [PWR_W-1:0] measured_power_value;
    logic held;
    logic protect;
    logic event_pulse;
    logic [7:0] rdata;
  } ipd_state_type;

  ipd_state_type st_reg;
  ipd_state_type st_next;

  logic [PAIR_W-1:0] pair_power;
  logic pair_valid;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // exponent values above the documented range behave as the top one
  function automatic logic [EXP_W-1:0] ipd_eff_exp(input logic [EXP_W-1:0] e);
    ipd_eff_exp = (e > EXP_MAX) ? EXP_MAX : e;
  endfunction

  // last count of a window of 2^(9+e) pairs
  function automatic logic [CNT_W-1:0] ipd_last_cnt(input logic [EXP_W-1:0] e);
    logic [CNT_W:0] len;
    len = (CNT_W+1)'(1) << (BASE_SHIFT + 32'(ipd_eff_exp(e)));
    ipd_last_cnt = CNT_W'(len - (CNT_W+1)'(1));
  endfunction

  // block sum divided by window length, clipped to the result width
  function automatic logic [PWR_W-1:0] ipd_mean(input logic [ACC_W-1:0] sum,
                                                input logic [EXP_W-1:0] e);
    logic [ACC_W-1:0] q;
    q = sum >> (BASE_SHIFT + 32'(ipd_eff_exp(e)));
    ipd_mean = (q > ACC_W'(PWR_SAT)) ? PWR_SAT : q[PWR_W-1:0];
  endfunction

  // ---------------------------------------------------------------
  // pair power stage
  // ---------------------------------------------------------------
  ipd_pair_power u_pair (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .sample_i(sample_i),
    .sample_q(sample_q),
    .sample_valid(sample_valid),
    .pair_power(pair_power),
    .pair_valid(pair_valid)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [ACC_W-1:0] sum;
    logic [PWR_W-1:0] mean;
    logic window_done;
    sum = '0;
    mean = '0;
    window_done = 1'b0;
    st_next = st_reg;
    st_next.event_pulse = 1'b0;

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        OFS_THR_LOW: begin
          st_next.power_limit_value[7:0] = reg_wdata;
        end
        OFS_THR_HIGH: begin
          st_next.power_limit_value[PWR_W-1:8] = reg_wdata[HIGH_W-1:0];
        end
        OFS_AVG_CTRL: begin
          st_next.power_calc_enable = reg_wdata[ENABLE_BIT];
          st_next.averaging_length_exponent = reg_wdata[EXP_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // release of the held peak; a new crossing below still wins
    if (irq_cleared) begin
      st_next.held = 1'b0;
      st_next.protect = 1'b0;
    end

    // accumulate over the window
    if (!st_reg.power_calc_enable) begin
      st_next.acc = '0;
      st_next.cnt = '0;
    end else if (pair_valid) begin
      sum = st_reg.acc + ACC_W'(pair_power);
      // a window shortened mid-count ends at once instead of wrapping
      window_done = (st_reg.cnt >= ipd_last_cnt(st_reg.averaging_length_exponent));
      if (window_done) begin
        mean = ipd_mean(sum, st_reg.averaging_length_exponent);
        st_next.acc = '0;
        st_next.cnt = '0;
      end else begin
        st_next.acc = sum;
        st_next.cnt = st_reg.cnt + CNT_W'(1);
      end
    end

    // result update, peak hold and threshold compare
    if (window_done) begin
      if (st_reg.held && !irq_cleared) begin
        if (mean > st_reg.measured_power_value) begin
          st_next.measured_power_value = mean;
        end
      end else begin
        st_next.measured_power_value = mean;
      end
      if (mean > st_reg.power_limit_value) begin
        st_next.held = 1'b1;
        st_next.protect = 1'b1;
        st_next.event_pulse = 1'b1;
        if (st_reg.held && !irq_cleared && mean < st_reg.measured_power_value) begin
          st_next.measured_power_value = st_reg.measured_power_value;
        end
      end
    end

    // read data, reserved bits as zero
    if (reg_rd) begin
      case (reg_addr)
        OFS_THR_LOW: st_next.rdata = st_reg.power_limit_value[7:0];
        OFS_THR_HIGH: st_next.rdata = {3'h0, st_reg.power_limit_value[PWR_W-1:8]};
        OFS_AVG_CTRL: st_next.rdata = {st_reg.power_calc_enable, 3'h0,
                                       st_reg.averaging_length_exponent};
        OFS_PWR_LOW: st_next.rdata = st_reg.measured_power_value[7:0];
        OFS_PWR_HIGH: st_next.rdata = {3'h0, st_reg.measured_power_value[PWR_W-1:8]};
        default: st_next.rdata = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
      st_reg.power_calc_enable <= RST_ENABLE;
      st_reg.averaging_length_exponent <= RST_EXP;
      st_reg.power_limit_value <= RST_THR;
      st_reg.measured_power_value <= RST_PWR;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign power_cross_event = st_reg.event_pulse;
  assign power_protect_flag = st_reg.protect;

endmodule

`default_nettype wire

// ---- ipd_detector_tb.sv ----
`timescale 1ns/100ps
`default_nettype none

module ipd_detector_tb;
  import ipd_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic irq_cleared = 1'b0;
  logic run = 1'b0;
  logic [6:0] i_top = 7'h0a;
  logic [6:0] q_top = 7'h7b;
  logic [7:0] reg_rdata;
  logic [SAMPLE_W-1:0] sample_i, sample_q;
  logic sample_valid, power_cross_event, power_protect_flag;
  logic rd_seen = 1'b0;
  logic [7:0] exp_q[$];
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  int ev_cnt = 0;
  int ev_base = 0;

  always #25 sys_clk = ~sys_clk;

  ipd_detector ipd_detector_inst (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sample_i(sample_i), .sample_q(sample_q), .sample_valid(sample_valid),
    .irq_cleared(irq_cleared), .power_cross_event(power_cross_event),
    .power_protect_flag(power_protect_flag));
  ipd_src ipd_src_inst (.sys_clk(sys_clk), .run(run), .i_top(i_top), .q_top(q_top),
    .sample_i(sample_i), .sample_q(sample_q), .sample_valid(sample_valid));

  // ----
  // tasks
  // ----
  task automatic end_sim;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] want);
    checked++;
    if (got !== want) begin
      n_mismatch++;
      $display("Error t=%0t got %h exp %h", $time, got, want);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] want);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    exp_q.push_back(want);
    @(negedge sys_clk);
    reg_rd = 1'b0;
  endtask
  task automatic rdp(input logic [12:0] p);
    rd(OFS_PWR_LOW, p[7:0]);
    rd(OFS_PWR_HIGH, {3'h0, p[12:8]});
  endtask
  task automatic flag(input logic f);
    check({7'h0, power_protect_flag}, {7'h0, f});
  endtask
  task automatic hold(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // ----
  // read watcher and timeout
  // ----
  always @(posedge sys_clk) rd_seen <= reg_rd;
  always @(negedge sys_clk) begin
    if (power_cross_event) ev_cnt++;
  end
  always @(negedge sys_clk) begin
    if (rd_seen && exp_q.size() > 0) check(reg_rdata, exp_q.pop_front());
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 10000) begin
      n_mismatch++;
      end_sim();
    end
  end

  // ----
  // scenarios
  // ----
  initial begin
    hold(5);
    nrst = 1'b1;
    for (int k = 0; k < 6; k++) rd(OFS_THR_LOW + 12'(k), 8'h00);
    wr(OFS_THR_HIGH, 8'hff);
    wr(OFS_THR_LOW, 8'h7d);
    wr(OFS_PWR_LOW, 8'h55);
    wr(OFS_AVG_CTRL, 8'h70);
    rd(OFS_THR_HIGH, 8'h1f);
    rd(OFS_AVG_CTRL, 8'h00);
    run = 1'b1;
    hold(1100);
    rdp(13'h0000);
    wr(OFS_THR_HIGH, 8'h00);
    wr(OFS_AVG_CTRL, 8'h80);
    hold(1100);
    rdp(13'h007d);
    flag(1'b0);
    wr(OFS_THR_LOW, 8'h7c);
    hold(1100);
    flag(1'b1);
    i_top = 7'h03;
    q_top = 7'h00;
    hold(1100);
    rdp(13'h007d);
    irq_cleared = 1'b1;
    hold(1);
    irq_cleared = 1'b0;
    hold(1100);
    flag(1'b0);
    rdp(13'h0009);
    ev_base = ev_cnt;
    wr(OFS_AVG_CTRL, 8'h01);
    i_top = 7'h0a;
    q_top = 7'h7b;
    wr(OFS_AVG_CTRL, 8'h81);
    rd(OFS_AVG_CTRL, 8'h81);
    hold(600);
    flag(1'b0);
    hold(500);
    flag(1'b1);
    check(8'(ev_cnt - ev_base), 8'h01);
    end_sim();
  end
endmodule

bind ipd_detector ipd_chk ipd_chk_inst (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .sample_i(sample_i), .sample_q(sample_q), .sample_valid(sample_valid),
  .irq_cleared(irq_cleared), .power_cross_event(power_cross_event),
  .power_protect_flag(power_protect_flag));

`default_nettype wire

// ---- ipd_pair_power.sv ----
`timescale 1ns/100ps
`default_nettype none

module ipd_pair_power (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // sample input
  input wire logic [ipd_pkg::SAMPLE_W-1:0] sample_i,
  input wire logic [ipd_pkg::SAMPLE_W-1:0] sample_q,
  input wire logic sample_valid,
  // pair power output
  output logic [ipd_pkg::PAIR_W-1:0] pair_power,
  output logic pair_valid
);
  import ipd_pkg::*;

  typedef struct packed {
    logic [PAIR_W-1:0] power;
    logic valid;
  } ipd_pp_state_type;

  ipd_pp_state_type st_reg;
  ipd_pp_state_type st_next;

  logic signed [MSB_USED-1:0] i_top;
  logic signed [MSB_USED-1:0] q_top;
  logic signed [PAIR_W-1:0] sq_i;
  logic signed [PAIR_W-1:0] sq_q;

  // ---------------------------------------------------------------
  // squares of the upper bits only
  // ---------------------------------------------------------------
  assign i_top = sample_i[SAMPLE_W-1 -: MSB_USED];
  assign q_top = sample_q[SAMPLE_W-1 -: MSB_USED];
  assign sq_i = PAIR_W'(i_top) * PAIR_W'(i_top);
  assign sq_q = PAIR_W'(q_top) * PAIR_W'(q_top);

  always_comb begin
    st_next = st_reg;
    st_next.valid = sample_valid;
    if (sample_valid) begin
      st_next.power = PAIR_W'(unsigned'(sq_i) + unsigned'(sq_q));
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pair_power = st_reg.power;
  assign pair_valid = st_reg.valid;

endmodule

`default_nettype wire

// ---- ipd_pkg.sv ----
package ipd_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFS_THR_LOW = 12'h060;
  localparam logic [11:0] OFS_THR_HIGH = 12'h061;
  localparam logic [11:0] OFS_AVG_CTRL = 12'h062;
  localparam logic [11:0] OFS_PWR_LOW = 12'h063;
  localparam logic [11:0] OFS_PWR_HIGH = 12'h064;

  // ---------------------------------------------------------------
  // field layout and reset values
  // ---------------------------------------------------------------
  localparam int unsigned ENABLE_BIT = 7;
  localparam int unsigned EXP_W = 4;
  localparam int unsigned HIGH_W = 5;
  localparam int unsigned PWR_W = 13;
  localparam logic [0:0] RST_ENABLE = 1'h0;
  localparam logic [3:0] RST_EXP = 4'h0;
  localparam logic [12:0] RST_THR = 13'h0000;
  localparam logic [12:0] RST_PWR = 13'h0000;
  localparam logic [3:0] EXP_MAX = 4'ha;

  // ---------------------------------------------------------------
  // datapath sizing
  // ---------------------------------------------------------------
  localparam int unsigned SAMPLE_W = 16;
  localparam int unsigned MSB_USED = 7;
  localparam int unsigned PAIR_W = 14;
  localparam int unsigned BASE_SHIFT = 9;
  localparam int unsigned MAX_SHIFT = 19;
  localparam int unsigned CNT_W = 19;
  localparam int unsigned ACC_W = 33;
  localparam logic [12:0] PWR_SAT = 13'h1fff;

endpackage

// ---- ipd_src.sv ----
`timescale 1ns/100ps
`default_nettype none

module ipd_src (
  // clock and stream control
  input wire logic sys_clk,
  input wire logic run,
  input wire logic [6:0] i_top,
  input wire logic [6:0] q_top,
  // sample stream
  output logic [ipd_pkg::SAMPLE_W-1:0] sample_i,
  output logic [ipd_pkg::SAMPLE_W-1:0] sample_q,
  output logic sample_valid
);
  import ipd_pkg::*;
  integer seed = 32'h7b27;
  initial begin
    sample_i = '0;
    sample_q = '0;
    sample_valid = 1'b0;
  end
  // ----
  // low bits random, idle samples are noise
  // ----
  always @(negedge sys_clk) begin
    sample_valid <= run;
    sample_i <= run ? {i_top, 9'($random(seed))} : 16'($random(seed));
    sample_q <= run ? {q_top, 9'($random(seed))} : 16'($random(seed));
  end
endmodule

`default_nettype wire
